// >>> verilog/dlt_pkg.sv
// Shared constants for the lane timing pair: line codes, time figures, cycle counts.
// Assumes a 100 MHz system clock on both ends.
package dlt_pkg;
    // ------------------------------------------------------------
    // Clock and unit interval
    // ------------------------------------------------------------
    localparam int CLK_PS = 10000;
    localparam int PCLK_KHZ = 75000;
    localparam int UI_PS = 1000000000 / (12 * PCLK_KHZ); // RULE1

    function automatic int cyc_min(input int ps);
        int c;
        c = (ps + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_max(input int ps);
        int c;
        c = ps / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // ------------------------------------------------------------
    // Line states and framing
    // ------------------------------------------------------------
    localparam logic [1:0] LP11 = 2'h3;
    localparam logic [1:0] LP01 = 2'h1;
    localparam logic [1:0] LP10 = 2'h2;
    localparam logic [1:0] LP00 = 2'h0;
    localparam logic [7:0] SYNC_BYTE = 8'hb8;
    localparam int LANE_W = 8;
    localparam int LANES = 2;

    // ------------------------------------------------------------
    // Time figures
    // ------------------------------------------------------------
    localparam int T_LPX_NS = 50;
    localparam int T_CPREP_MIN_NS = 38;
    localparam int T_CPREP_MAX_NS = 95;
    localparam int T_CPZ_NS = 300;
    localparam int T_CPRE_UI = 8;
    localparam int T_CPOST_NS = 60;
    localparam int T_CPOST_UI = 52;
    localparam int T_CTRAIL_NS = 60;
    localparam int T_DPREP_NS = 40;
    localparam int T_DPREP_UI = 4;
    localparam int T_DPREP_MAX_NS = 85;
    localparam int T_DPREP_MAX_UI = 6;
    localparam int T_DPZ_NS = 145;
    localparam int T_DPZ_UI = 10;
    localparam int T_TRAIL_NS = 60;
    localparam int T_TRAIL_UI = 4;
    localparam int T_EOT_NS = 105;
    localparam int T_EOT_UI = 12;
    localparam int T_EXIT_NS = 100;
    localparam int T_WAKE_MS = 1;
    localparam int T_CSETTLE_NS = 95;
    localparam int T_DSETTLE_NS = 85;
    localparam int T_DSETTLE_UI = 6;

    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam int LPX_CYC = cyc_min(T_LPX_NS * 1000);
    localparam int CPREP_CYC = cyc_min(T_CPREP_MIN_NS * 1000);
    localparam int CPREP_MAX_CYC = cyc_max(T_CPREP_MAX_NS * 1000);
    localparam int CZERO_CYC = cyc_min(T_CPZ_NS * 1000) - CPREP_CYC;
    localparam int CPRE_CYC = cyc_min(T_CPRE_UI * UI_PS);
    localparam int CPOST_CYC = cyc_min(T_CPOST_NS * 1000 + T_CPOST_UI * UI_PS);
    localparam int CTRAIL_CYC = cyc_min(T_CTRAIL_NS * 1000);
    localparam int DPREP_CYC = cyc_min(T_DPREP_NS * 1000 + T_DPREP_UI * UI_PS);
    localparam int DPREP_MAX_CYC = cyc_max(T_DPREP_MAX_NS * 1000 + T_DPREP_MAX_UI * UI_PS);
    localparam int DZERO_CYC = cyc_min(T_DPZ_NS * 1000 + T_DPZ_UI * UI_PS) - DPREP_CYC;
    localparam int TRAIL_CYC = cyc_min(T_TRAIL_NS * 1000 + T_TRAIL_UI * UI_PS);
    localparam int EOT_MAX_CYC = cyc_max(T_EOT_NS * 1000 + T_EOT_UI * UI_PS);
    localparam int EXIT_CYC = cyc_min(T_EXIT_NS * 1000);
    localparam int WAKE_CYC = cyc_min(T_WAKE_MS * 1000000000);
    localparam int CSETTLE_CYC = cyc_min(T_CSETTLE_NS * 1000);
    localparam int DSETTLE_CYC = cyc_min(T_DSETTLE_NS * 1000 + T_DSETTLE_UI * UI_PS);
endpackage

// >>> verilog/dlt_lane_if.sv
// Lane wires between transmitting end and receiving end.
// Bench joins both modports; no clocking here.
`timescale 1ns/1ps
interface dlt_lane_if;
    logic [1:0] clk_lp;
    logic clk_hs_en;
    logic clk_hs;
    logic [1:0] d0_lp;
    logic [1:0] d1_lp;
    logic d_hs_en;
    logic [1:0] d_hs;
    logic clk_term;
    logic d_term;

    modport tx (
        output clk_lp, clk_hs_en, clk_hs, d0_lp, d1_lp, d_hs_en, d_hs
    );
    modport rx (
        input clk_lp, clk_hs_en, clk_hs, d0_lp, d1_lp, d_hs_en, d_hs,
        output clk_term, d_term
    );
endinterface

// >>> verilog/dlt_tx.sv
// Transmitting end: sequences clock lane and two data lanes through LP/HS states.
// Assumes the receiving end on the lane interface; link clock made here by divider.
//
// Operation
// RULE1: Unit interval is one twelfth pixel period
// RULE2: Clock runs 60ns+52UI after data burst
// RULE3: Clock runs 8UI before data leaves LP
// RULE4: Clock prepare lasts 38 to 95 ns
// RULE5: Receiver ignores clock HS during settle window
// RULE6: Receiver terminates clock lane within 38 ns
// RULE7: Clock prepare plus zero at least 300ns
// RULE8: Receiver terminates data lane within 35ns+4UI
// RULE9: Every LP state held at least 50ns
// RULE10: Data prepare 40ns+4UI to 85ns+6UI
// RULE11: Receiver ignores data HS during settle window
// RULE12: LP-11 within 105ns+12UI of trail start
// RULE13: LP-11 held 100ns after each burst
// RULE14: ULPS wake-up recovery at least 1ms
// RULE15: Entry LP-11,01,00,HS-0; exit trail then LP-11
`timescale 1ns/1ps
module dlt_tx
    import dlt_pkg::*;
#(
    parameter int LINK_HALF = 8,
    parameter int WAKE_CNT = WAKE_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Word stream in
    input wire logic in_valid_i,
    input wire logic [LANES*LANE_W-1:0] in_data_i,
    output logic in_ready_o,
    // Power control and status
    input wire logic ulps_req_i,
    output logic busy_o,
    output logic ulps_o,
    // Lanes
    dlt_lane_if.tx lane
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (LINK_HALF < 4) $error("LINK_HALF too small");
    if (WAKE_CNT < 1 || WAKE_CNT > 131071) $error("WAKE_CNT out of range");
    if (CPREP_CYC > CPREP_MAX_CYC) $error("clock prepare too long");
    if (DPREP_CYC > DPREP_MAX_CYC) $error("data prepare too long");
    if (TRAIL_CYC > EOT_MAX_CYC) $error("trail too long");

    typedef enum logic [4:0] {
        ST_STOP = 5'h00, ST_CLP01 = 5'h01, ST_CLP00 = 5'h02, ST_CPREP = 5'h03,
        ST_CZERO = 5'h04, ST_CPRE = 5'h05, ST_DLP01 = 5'h06, ST_DLP00 = 5'h07,
        ST_DPREP = 5'h08, ST_DZERO = 5'h09, ST_DSEND = 5'h0a, ST_DTRAIL = 5'h0b,
        ST_CPOST = 5'h0c, ST_CTRAIL = 5'h0d, ST_EXIT = 5'h0e, ST_U10 = 5'h0f,
        ST_ULPS = 5'h10, ST_WAKE = 5'h11
    } dlt_tx_st_e;

    localparam int DW = LANES * LANE_W;

    dlt_tx_st_e st_q;
    logic [16:0] cnt_q;
    logic [7:0] div_q;
    logic tick_edge;
    logic tick_mid;
    logic done;
    logic [DW-1:0] buf_q [2];
    logic buf_wp_q;
    logic buf_rp_q;
    logic [1:0] buf_cnt_q;
    logic [1:0] buf_cnt_d;
    logic buf_valid;
    logic push;
    logic pop;
    logic [7:0] sh0_q;
    logic [7:0] sh1_q;
    logic [2:0] bit_q;
    logic last_q;
    logic [1:0] d_hs_q;
    logic clk_hs_q;
    logic clk_run;
    logic [1:0] clk_lp_q;
    logic [1:0] d_lp_q;
    logic clk_en_q;
    logic d_en_q;
    logic busy_q;
    logic ulps_q;

    function automatic logic [16:0] ld(input int n);
        return 17'(n - 1);
    endfunction

    // ------------------------------------------------------------
    // Two-entry word buffer
    // ------------------------------------------------------------
    assign buf_valid = (buf_cnt_q != 2'h0);
    assign push = in_valid_i & in_ready_o;
    assign pop = (st_q == ST_DSEND) & tick_mid & (bit_q == 3'h7) & buf_valid;
    assign buf_cnt_d = buf_cnt_q + 2'(push) - 2'(pop);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            buf_cnt_q <= 2'h0;
            buf_wp_q <= 1'b0;
            buf_rp_q <= 1'b0;
            in_ready_o <= 1'b0;
        end else begin
            buf_cnt_q <= buf_cnt_d;
            in_ready_o <= (buf_cnt_d != 2'h2);
            if (push) begin
                buf_wp_q <= ~buf_wp_q;
            end
            if (pop) begin
                buf_rp_q <= ~buf_rp_q;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            buf_q[buf_wp_q] <= in_data_i;
        end
    end

    // ------------------------------------------------------------
    // Link clock divider
    // ------------------------------------------------------------
    assign tick_edge = (div_q == 8'(LINK_HALF - 1));
    assign tick_mid = (div_q == 8'(LINK_HALF / 2 - 1));
    assign clk_run = st_q inside {ST_CPRE, ST_DLP01, ST_DLP00, ST_DPREP,
                                  ST_DZERO, ST_DSEND, ST_DTRAIL, ST_CPOST};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= 8'h00;
            clk_hs_q <= 1'b0;
        end else begin
            div_q <= tick_edge ? 8'h00 : div_q + 8'h01;
            if (!clk_run) begin
                clk_hs_q <= 1'b0;
            end else if (tick_edge) begin
                clk_hs_q <= ~clk_hs_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Lane sequencer
    // ------------------------------------------------------------
    assign done = (cnt_q == 17'h00000);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= ST_STOP;
            cnt_q <= 17'h00000;
        end else begin
            if (!done) begin
                cnt_q <= cnt_q - 17'h00001;
            end
            unique case (st_q)
                ST_STOP: if (done) begin // RULE13
                    if (ulps_req_i) begin
                        st_q <= ST_U10;
                        cnt_q <= ld(LPX_CYC);
                    end else if (buf_valid) begin
                        st_q <= ST_CLP01; // RULE15
                        cnt_q <= ld(LPX_CYC); // RULE9
                    end
                end
                ST_CLP01: if (done) begin
                    st_q <= ST_CLP00;
                    cnt_q <= ld(LPX_CYC); // RULE9
                end
                ST_CLP00: if (done) begin
                    st_q <= ST_CPREP;
                    cnt_q <= ld(CPREP_CYC); // RULE4
                end
                ST_CPREP: if (done) begin
                    st_q <= ST_CZERO;
                    cnt_q <= ld(CZERO_CYC); // RULE7
                end
                ST_CZERO: if (done) begin
                    st_q <= ST_CPRE;
                    cnt_q <= ld(CPRE_CYC + 2 * LINK_HALF); // RULE3
                end
                ST_CPRE: if (done) begin
                    st_q <= ST_DLP01;
                    cnt_q <= ld(LPX_CYC);
                end
                ST_DLP01: if (done) begin
                    st_q <= ST_DLP00;
                    cnt_q <= ld(LPX_CYC);
                end
                ST_DLP00: if (done) begin
                    st_q <= ST_DPREP;
                    cnt_q <= ld(DPREP_CYC); // RULE10
                end
                ST_DPREP: if (done) begin
                    st_q <= ST_DZERO;
                    cnt_q <= ld(DZERO_CYC);
                end
                ST_DZERO: if (done && tick_mid) begin
                    st_q <= ST_DSEND;
                end
                ST_DSEND: if (tick_mid && last_q) begin
                    st_q <= ST_DTRAIL;
                    cnt_q <= ld(TRAIL_CYC); // RULE12
                end
                ST_DTRAIL: if (done) begin
                    st_q <= ST_CPOST; // RULE15
                    cnt_q <= ld(CPOST_CYC); // RULE2
                end
                ST_CPOST: if (done) begin
                    st_q <= ST_CTRAIL;
                    cnt_q <= ld(CTRAIL_CYC);
                end
                ST_CTRAIL: if (done) begin
                    st_q <= ST_EXIT;
                    cnt_q <= ld(EXIT_CYC); // RULE13
                end
                ST_EXIT: if (done) begin
                    st_q <= ST_STOP;
                end
                ST_U10: if (done) begin
                    st_q <= ST_ULPS;
                    cnt_q <= ld(LPX_CYC);
                end
                ST_ULPS: if (done && !ulps_req_i) begin
                    st_q <= ST_WAKE;
                    cnt_q <= ld(WAKE_CNT); // RULE14
                end
                ST_WAKE: if (done) begin
                    st_q <= ST_EXIT;
                    cnt_q <= ld(EXIT_CYC);
                end
                default: begin
                    st_q <= ST_STOP;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Serializer, low byte on lane 0, LSB first
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh0_q <= 8'h00;
            sh1_q <= 8'h00;
            bit_q <= 3'h0;
            last_q <= 1'b0;
            d_hs_q <= 2'h0;
        end else if (st_q == ST_DZERO) begin
            sh0_q <= SYNC_BYTE;
            sh1_q <= SYNC_BYTE;
            bit_q <= 3'h0;
            last_q <= 1'b0;
            d_hs_q <= 2'h0;
        end else if (st_q == ST_DSEND && tick_mid) begin
            if (last_q) begin
                d_hs_q <= ~d_hs_q; // RULE15
            end else begin
                d_hs_q <= {sh1_q[0], sh0_q[0]};
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    last_q <= ~buf_valid;
                    sh0_q <= buf_q[buf_rp_q][LANE_W-1:0];
                    sh1_q <= buf_q[buf_rp_q][DW-1:LANE_W];
                end else begin
                    sh0_q <= {1'b0, sh0_q[7:1]};
                    sh1_q <= {1'b0, sh1_q[7:1]};
                end
            end
        end else if (st_q != ST_DSEND && st_q != ST_DTRAIL) begin
            d_hs_q <= 2'h0;
        end
    end

    // ------------------------------------------------------------
    // Line drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_lp_q <= LP11;
            d_lp_q <= LP11;
            clk_en_q <= 1'b0;
            d_en_q <= 1'b0;
            busy_q <= 1'b0;
            ulps_q <= 1'b0;
        end else begin
            clk_lp_q <= (st_q == ST_CLP01) ? LP01 :
                        (st_q inside {ST_U10, ST_WAKE}) ? LP10 :
                        (st_q inside {ST_STOP, ST_EXIT}) ? LP11 : LP00;
            d_lp_q <= (st_q == ST_DLP01) ? LP01 :
                      (st_q inside {ST_U10, ST_WAKE}) ? LP10 :
                      (st_q inside {ST_DLP00, ST_DPREP, ST_DZERO, ST_DSEND,
                                    ST_DTRAIL, ST_ULPS}) ? LP00 : LP11;
            clk_en_q <= st_q inside {ST_CPREP, ST_CZERO, ST_CPRE, ST_DLP01, ST_DLP00,
                                     ST_DPREP, ST_DZERO, ST_DSEND, ST_DTRAIL,
                                     ST_CPOST, ST_CTRAIL};
            d_en_q <= st_q inside {ST_DPREP, ST_DZERO, ST_DSEND, ST_DTRAIL};
            busy_q <= (st_q != ST_STOP);
            ulps_q <= (st_q == ST_ULPS);
        end
    end

    assign busy_o = busy_q;
    assign ulps_o = ulps_q;
    assign lane.clk_lp = clk_lp_q;
    assign lane.clk_hs_en = clk_en_q;
    assign lane.clk_hs = clk_hs_q;
    assign lane.d0_lp = d_lp_q;
    assign lane.d1_lp = d_lp_q;
    assign lane.d_hs_en = d_en_q;
    assign lane.d_hs = d_hs_q;
endmodule // dlt_tx

// >>> verilog/dlt_rx.sv
// Receiving end: samples lanes, enables termination, settles, aligns on sync byte.
// Assumes lane signals are asynchronous; clk_lp, clk_hs, d0_lp and d_hs pass two flip-flops; d1_lp, clk_hs_en and d_hs_en are not sampled.
`timescale 1ns/1ps
module dlt_rx
    import dlt_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Word stream out
    output logic [LANES*LANE_W-1:0] rx_data_o,
    output logic rx_valid_o,
    // Status
    output logic rx_burst_o,
    output logic rx_ulps_o,
    // Lanes
    dlt_lane_if.rx lane
);
    typedef enum logic [2:0] {
        DS_IDLE = 3'h0, DS_ENTRY = 3'h1, DS_SETTLE = 3'h2, DS_HUNT = 3'h3,
        DS_RECV = 3'h4, DS_ESC = 3'h5, DS_ULPS = 3'h6
    } dlt_rx_st_e;

    logic [6:0] s1_q;
    logic [6:0] s2_q;
    logic ck3_q;
    logic [1:0] clk_lp;
    logic [1:0] d_lp;
    logic [1:0] bits;
    logic edge_s;
    logic [4:0] csettle_q;
    logic clk_ok_q;
    dlt_rx_st_e st_q;
    logic [4:0] dsettle_q;
    logic [7:0] sh0_q;
    logic [7:0] sh1_q;
    logic [7:0] sh0_n;
    logic [7:0] sh1_n;
    logic [2:0] bit_q;
    logic clk_term_q;
    logic d_term_q;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= {LP11, 1'b0, LP11, 2'h0};
            s2_q <= {LP11, 1'b0, LP11, 2'h0};
            ck3_q <= 1'b0;
        end else begin
            s1_q <= {lane.clk_lp, lane.clk_hs, lane.d0_lp, lane.d_hs};
            s2_q <= s1_q;
            ck3_q <= s2_q[4];
        end
    end

    assign clk_lp = s2_q[6:5];
    assign d_lp = s2_q[3:2];
    assign bits = s2_q[1:0];
    assign edge_s = s2_q[4] ^ ck3_q;
    assign sh0_n = {bits[0], sh0_q[7:1]};
    assign sh1_n = {bits[1], sh1_q[7:1]};

    // ------------------------------------------------------------
    // Clock lane
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            csettle_q <= 5'h00;
            clk_ok_q <= 1'b0;
            clk_term_q <= 1'b0;
        end else begin
            clk_term_q <= (clk_lp == LP01) | (clk_lp == LP00 & clk_term_q); // RULE6
            if (clk_lp != LP00) begin
                csettle_q <= 5'(CSETTLE_CYC);
                clk_ok_q <= 1'b0;
            end else if (csettle_q != 5'h00) begin
                csettle_q <= csettle_q - 5'h01; // RULE5
            end else begin
                clk_ok_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Data lanes
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= DS_IDLE;
            dsettle_q <= 5'h00;
            sh0_q <= 8'h00;
            sh1_q <= 8'h00;
            bit_q <= 3'h0;
            rx_data_o <= '0;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            if (edge_s) begin
                sh0_q <= sh0_n;
                sh1_q <= sh1_n;
            end
            if (d_lp == LP11) begin
                st_q <= DS_IDLE;
            end else begin
                unique case (st_q)
                    DS_IDLE: begin
                        if (d_lp == LP01) st_q <= DS_ENTRY;
                        if (d_lp == LP10) st_q <= DS_ESC;
                    end
                    DS_ENTRY: if (d_lp == LP00) begin
                        st_q <= DS_SETTLE;
                        dsettle_q <= 5'(DSETTLE_CYC);
                    end
                    DS_SETTLE: begin
                        if (dsettle_q != 5'h00) begin
                            dsettle_q <= dsettle_q - 5'h01; // RULE11
                        end else if (clk_ok_q) begin
                            st_q <= DS_HUNT;
                        end
                    end
                    DS_HUNT: if (edge_s && sh0_n == SYNC_BYTE && sh1_n == SYNC_BYTE) begin
                        st_q <= DS_RECV;
                        bit_q <= 3'h0;
                    end
                    DS_RECV: if (edge_s) begin
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            rx_data_o <= {sh1_n, sh0_n};
                            rx_valid_o <= 1'b1;
                        end
                    end
                    DS_ESC: if (d_lp == LP00) st_q <= DS_ULPS;
                    DS_ULPS: begin
                    end
                    default: st_q <= DS_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Termination and status
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            d_term_q <= 1'b0;
            rx_burst_o <= 1'b0;
            rx_ulps_o <= 1'b0;
        end else begin
            d_term_q <= (d_lp == LP01) |
                        (d_lp == LP00 & st_q inside {DS_ENTRY, DS_SETTLE, DS_HUNT,
                                                     DS_RECV}); // RULE8
            rx_burst_o <= (st_q == DS_RECV);
            rx_ulps_o <= (st_q == DS_ULPS);
        end
    end

    assign lane.clk_term = clk_term_q;
    assign lane.d_term = d_term_q;
endmodule // dlt_rx

// >>> test/dlt_lane_checker.sv
// Timing checker on the lane wires between both ends.
// Assumes one 100 MHz domain; instantiated beside the lane interface.
`timescale 1ns/1ps
module dlt_lane_checker
    import dlt_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Lane wires
    input wire logic [1:0] clk_lp,
    input wire logic clk_hs_en,
    input wire logic clk_hs,
    input wire logic [1:0] d0_lp,
    input wire logic [1:0] d1_lp,
    input wire logic d_hs_en,
    input wire logic [1:0] d_hs,
    input wire logic clk_term,
    input wire logic d_term
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Cycles since clock lane left LP
    logic [8:0] zc_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) zc_q <= 9'h0;
        else if (!clk_hs_en) zc_q <= 9'h0;
        else if (zc_q != 9'h1ff) zc_q <= zc_q + 9'h1;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_hold; $changed(d0_lp) |=> $stable(d0_lp)[*4]; endproperty
    a_hold: assert property (p_hold) else $error("lp state too short");
    property p_zero; $rose(clk_hs) |-> zc_q >= 9'h1e; endproperty
    a_zero: assert property (p_zero) else $error("prepare plus zero short");
    property p_pre; $rose(d0_lp == LP01) |-> clk_hs_en && zc_q >= 9'h1f; endproperty
    a_pre: assert property (p_pre) else $error("clock not running");
    property p_post; $fell(d_hs_en) |-> clk_hs_en throughout (##12 1'b1); endproperty
    a_post: assert property (p_post) else $error("clock stopped early");
    property p_eot; $fell(d_hs_en) |-> $past(d_hs) != $past(d_hs, 11); endproperty
    a_eot: assert property (p_eot) else $error("trail too long");
    property p_exit; $fell(d_hs_en) |-> (d0_lp == LP11)[*8] ##1 (d0_lp == LP11)[*2]; endproperty
    a_exit: assert property (p_exit) else $error("exit too short");
    property p_order;
        $rose(d_hs_en) |-> $past(d0_lp, 6) == LP01 && $past(d0_lp) == LP00 && d1_lp == d0_lp;
    endproperty
    a_order: assert property (p_order) else $error("entry order wrong");
    property p_dterm; $rose(d0_lp == LP01) |-> ##[1:3] d_term; endproperty
    a_dterm: assert property (p_dterm) else $error("data term late");
    property p_cterm; $rose(clk_lp == LP01) |-> ##[1:3] clk_term; endproperty
    a_cterm: assert property (p_cterm) else $error("clock term late");
endmodule // dlt_lane_checker

// >>> test/dphy_lane_hs_lp_timing_test.sv
// Bench: transmitter and receiver joined by the lane interface.
// Assumes the design files and lane checker are compiled first.
`timescale 1ns/1ps
module dphy_lane_hs_lp_timing_test
    import dlt_pkg::*;
;
    typedef struct packed { logic [15:0] din; logic [15:0] exp; } dlt_row_s;
    dlt_row_s rows[5] = '{'{16'h0001, 16'h0001}, '{16'h8000, 16'h8000},
        '{16'hffff, 16'hffff}, '{16'h0000, 16'h0000}, '{16'ha55a, 16'ha55a}};
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic in_valid_i = 1'b0;
    logic [15:0] in_data_i = 16'h0;
    logic ulps_req_i = 1'b0;
    logic in_ready_o, busy_o, ulps_o, rx_valid_o, rx_burst_o, rx_ulps_o;
    logic [15:0] rx_data_o;
    logic [15:0] got[$];
    logic saw_full = 1'b0;
    logic saw_burst = 1'b0;
    int n_fail = 0;
    int n_compared = 0;
    int k;
    always #5 clk_i = ~clk_i;
    dlt_lane_if lane_bus();
    dlt_tx #(.LINK_HALF(8), .WAKE_CNT(50)) dlt_tx_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .in_valid_i(in_valid_i), .in_data_i(in_data_i), .in_ready_o(in_ready_o),
        .ulps_req_i(ulps_req_i), .busy_o(busy_o), .ulps_o(ulps_o), .lane(lane_bus));
    dlt_rx dlt_rx_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .rx_data_o(rx_data_o),
        .rx_valid_o(rx_valid_o), .rx_burst_o(rx_burst_o), .rx_ulps_o(rx_ulps_o),
        .lane(lane_bus));
    dlt_lane_checker dlt_lane_checker_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .clk_lp(lane_bus.clk_lp), .clk_hs_en(lane_bus.clk_hs_en), .clk_hs(lane_bus.clk_hs),
        .d0_lp(lane_bus.d0_lp), .d1_lp(lane_bus.d1_lp), .d_hs_en(lane_bus.d_hs_en),
        .d_hs(lane_bus.d_hs), .clk_term(lane_bus.clk_term), .d_term(lane_bus.d_term));
    always @(posedge clk_i) begin
        if (rx_valid_o === 1'b1) got.push_back(rx_data_o);
        if (rst_n_i && in_valid_i && in_ready_o === 1'b0) saw_full <= 1'b1;
        if (rx_burst_o === 1'b1) saw_burst <= 1'b1;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic step();
        @(posedge clk_i);
        k++;
        if (k > 5000) begin
            n_fail++;
            conclude();
        end
    endtask
    task automatic send(input logic [15:0] w);
        in_valid_i <= 1'b1;
        in_data_i <= w;
        k = 0;
        do step(); while (in_ready_o !== 1'b1);
    endtask
    task automatic idle_wait(input int n);
        k = 0;
        do step(); while (busy_o !== 1'b0 || got.size() < n);
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        check(16'(lane_bus.d0_lp), 16'(LP11));
        check(16'(in_ready_o), 16'h0);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 5; i++) send(rows[i].din);
        in_valid_i <= 1'b0;
        idle_wait(5);
        check(16'(got.size()), 16'h5);
        for (int i = 0; i < 5; i++) check(got[i], rows[i].exp);
        check(16'(saw_full), 16'h1);
        check(16'(saw_burst), 16'h1);
        check(16'(rx_burst_o), 16'h0);
        ulps_req_i <= 1'b1;
        k = 0;
        do step(); while (ulps_o !== 1'b1 || rx_ulps_o !== 1'b1);
        check(16'(lane_bus.d0_lp), 16'(LP00));
        ulps_req_i <= 1'b0;
        k = 0;
        do step(); while (lane_bus.d0_lp !== LP11);
        check(16'(k >= 50), 16'h1);
        got.delete();
        idle_wait(0);
        send(16'h3c5a);
        in_valid_i <= 1'b0;
        idle_wait(1);
        check(got[0], 16'h3c5a);
        check(16'(rx_ulps_o), 16'h0);
        conclude();
    end
endmodule // dphy_lane_hs_lp_timing_test
